// ===== src/adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// register byte offsets
`define ADC_REG_CTRL      8'h00
`define ADC_REG_SAMPLE    8'h04
`define ADC_REG_CONVERT   8'h08
`define ADC_REG_READY_DLY 8'h0C
`define ADC_REG_SPACING   8'h10
`define ADC_REG_STATUS    8'h14
`define ADC_REG_CODE      8'h18

// control field positions
`define ADC_CTRL_EDGE_BIT 0
`define ADC_CTRL_FMT_LSB  1
`define ADC_CTRL_FMT_MSB  2
// status field positions
`define ADC_STAT_READY_BIT   0
`define ADC_STAT_SAMPLE_BIT  1
`define ADC_STAT_IGNORED_BIT 2
`define ADC_STAT_PEND_LSB    8

// clock and timing, times in ns
`define ADC_CLK_NS        40
`define ADC_SAMPLE_NS     200
`define ADC_CONVERT_NS    1000
`define ADC_READY_DLY_NS  80
`define ADC_SPACING_NS    400
// least times round up to whole cycles
`define ADC_SAMPLE_CYC    ((`ADC_SAMPLE_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_CONVERT_CYC   ((`ADC_CONVERT_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_READY_DLY_CYC ((`ADC_READY_DLY_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_SPACING_CYC   ((`ADC_SPACING_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

// structure sizes
`define ADC_SLOTS         4
`define ADC_CNT_W         16
`define ADC_OUT_W_DEF     12

`endif

// ===== src/adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic {
    EDGE_RISE = 1'b0,
    EDGE_FALL = 1'b1
  } edge_sel_e;

  typedef enum logic [1:0] {
    FMT_UNSIGNED = 2'b00,
    FMT_TWOS     = 2'b01,
    FMT_OFFSET   = 2'b10
  } code_fmt_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

endpackage

// ===== src/adc_conversion_sequencer.sv
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
// Overview of operation
// - the output code width is a parameter settable from 1 to 32 bits.
// - a conversion starts on the rising or falling trigger edge per the edge select.
// - sampling of the input begins one clock after the accepted trigger edge is detected.
// - sampling ends and the input is captured once the sample interval has elapsed.
// - the output code takes the result the conversion time after sampling begins.
// - data-ready drops when the code changes and rises again after the ready delay.
// - a trigger later than the minimum spacing after the last start overlaps while one of the four slots is free.
// - a trigger within the minimum spacing is ignored and pending work is untouched.
// - the code is unsigned binary, two's complement or offset binary as selected.
// - the edge select has two values, low-to-high and high-to-low.
// - out of reset data-ready takes its configured initial state.
// - the code holds its configured initial value until the first result.
module adc_conversion_sequencer #(
  parameter int                     output_width         = `ADC_OUT_W_DEF,
  parameter logic                   ready_initial_state  = 1'b1,
  parameter logic [31:0]            output_initial_value = 32'h0000_0000
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire adc_seq_pkg::reg_req_s    bus_req,
  output logic [31:0]                   bus_rdata,
  input  wire logic                     trig_pin,
  input  wire logic [output_width-1:0]  sample_in,
  output logic                          sampling,
  output logic [output_width-1:0]       code_out,
  output logic                          data_ready
);
  import adc_seq_pkg::*;

  localparam int CW = `ADC_CNT_W;
  localparam int NS = `ADC_SLOTS;
  localparam int IW = $clog2(NS);

  // configuration registers
  edge_sel_e          trigger_edge_select;
  code_fmt_e          signed_format;
  logic [CW-1:0]      sample_cnt;
  logic [CW-1:0]      convert_cnt;
  logic [CW-1:0]      ready_cnt;
  logic [CW-1:0]      spacing_cnt;
  logic               trig_ignored;

  // pin synchronisers
  logic                    trig_meta;
  logic                    trig_sync;
  logic                    trig_prev;
  logic [output_width-1:0] samp_meta;
  logic [output_width-1:0] samp_sync;

  // spacing and data-ready timers
  logic [CW-1:0]      since_start;
  logic [CW-1:0]      ready_timer;

  // per-slot conversion tracking
  logic [NS-1:0]                   slot_busy;
  logic [NS-1:0]                   slot_held;
  logic [CW-1:0]                   slot_age  [NS];
  logic [output_width-1:0]         slot_data [NS];

  logic                    trig_edge;
  logic                    trig_accept;
  logic                    trig_drop;
  logic                    alloc_ok;
  logic [IW-1:0]           alloc_idx;
  logic                    done_ok;
  logic [IW-1:0]           done_idx;
  logic [output_width-1:0] next_code;
  logic                    any_sampling;
  logic [IW:0]             pend_count;

  // two flip-flops before any logic sees the trigger pin or the sample word
  // the sample word crosses bit by bit, so it must hold still around the capture
  // point; a word moving at that edge can mix old and new bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      samp_meta <= '0;
      samp_sync <= '0;
    end else begin
      trig_meta <= trig_pin;
      trig_sync <= trig_meta;
      samp_meta <= sample_in;
      samp_sync <= samp_meta;
    end
  end

  // previous level for edge detection, read from the second stage only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_sync;
    end
  end

  // edge select picks the transition that starts a conversion
  always_comb begin
    unique case (trigger_edge_select)
      EDGE_RISE: trig_edge = trig_sync & ~trig_prev;
      EDGE_FALL: trig_edge = ~trig_sync & trig_prev;
    endcase
  end

  // lowest free slot takes the next conversion
  always_comb begin
    alloc_ok  = 1'b0;
    alloc_idx = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (!slot_busy[i]) begin
        alloc_ok  = 1'b1;
        alloc_idx = IW'(i);
      end
    end
  end

  // a trigger too close to the last start, or with every slot busy, is dropped
  assign trig_accept = trig_edge && (since_start > spacing_cnt) && alloc_ok;
  assign trig_drop   = trig_edge && !trig_accept;

  // cycles since the last accepted start, saturating so an idle block accepts at once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      since_start <= '1;
    end else if (trig_accept) begin
      since_start <= CW'(1);
    end else if (since_start != '1) begin
      since_start <= since_start + CW'(1);
    end
  end

  // each slot ages on its own, captures at the sample count, retires at convert
  for (genvar s = 0; s < NS; s++) begin : g_slot
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        slot_busy[s] <= 1'b0;
        slot_held[s] <= 1'b0;
        slot_age[s]  <= '0;
        slot_data[s] <= '0;
      end else if (trig_accept && alloc_idx == IW'(s)) begin
        slot_busy[s] <= 1'b1;
        slot_held[s] <= 1'b0;
        slot_age[s]  <= CW'(1);
      end else if (slot_busy[s]) begin
        slot_age[s] <= slot_age[s] + CW'(1);
        if (!slot_held[s] && slot_age[s] >= sample_cnt) begin
          slot_held[s] <= 1'b1;
          slot_data[s] <= samp_sync;
        end
        if (slot_age[s] >= convert_cnt) begin
          slot_busy[s] <= 1'b0;
        end
      end
    end
  end

  // the slot whose age hits the conversion count delivers; ages never tie
  always_comb begin
    done_ok  = 1'b0;
    done_idx = '0;
    for (int i = 0; i < NS; i++) begin
      if (slot_busy[i] && slot_age[i] >= convert_cnt) begin
        done_ok  = 1'b1;
        done_idx = IW'(i);
      end
    end
  end

  // format the finished word; the raw word counts up from the bottom of the range
  always_comb begin
    logic [output_width-1:0] raw;
    raw = slot_data[done_idx];
    // a slot retiring with a sample count above its convert count uses the live input
    if (!slot_held[done_idx]) begin
      raw = samp_sync;
    end
    unique case (signed_format)
      FMT_TWOS: begin
        // only the top bit moves, so a one-bit code stays legal
        next_code                 = raw;
        next_code[output_width-1] = ~raw[output_width-1];
      end
      FMT_OFFSET: next_code = raw;
      default:   next_code = raw;
    endcase
  end

  // output code holds its initial value until the first result lands
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      code_out <= output_initial_value[output_width-1:0];
    end else if (done_ok) begin
      code_out <= next_code;
    end
  end

  // data-ready falls with each new code and returns after the ready delay
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_ready  <= ready_initial_state;
      ready_timer <= '0;
    end else if (done_ok) begin
      data_ready  <= 1'b0;
      ready_timer <= (ready_cnt == '0) ? CW'(1) : ready_cnt;
    end else if (ready_timer != '0) begin
      ready_timer <= ready_timer - CW'(1);
      if (ready_timer == CW'(1)) begin
        data_ready <= 1'b1;
      end
    end
  end

  // sampling is high while any slot is still before its capture point
  always_comb begin
    any_sampling = 1'b0;
    pend_count   = '0;
    for (int i = 0; i < NS; i++) begin
      if (slot_busy[i]) begin
        pend_count = pend_count + (IW + 1)'(1);
      end
      if (slot_busy[i] && !slot_held[i] && slot_age[i] < sample_cnt) begin
        any_sampling = 1'b1;
      end
    end
  end

  // registered so the pin follows the trigger edge by one cycle like the slot
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sampling <= 1'b0;
    end else begin
      sampling <= trig_accept || (any_sampling && !(done_ok && pend_count == (IW + 1)'(1)))
                  ? 1'b1 : any_sampling;
    end
  end

  // control and timing registers; timings are clock counts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trigger_edge_select <= EDGE_RISE;
      signed_format       <= FMT_UNSIGNED;
      sample_cnt          <= CW'(`ADC_SAMPLE_CYC);
      convert_cnt         <= CW'(`ADC_CONVERT_CYC);
      ready_cnt           <= CW'(`ADC_READY_DLY_CYC);
      spacing_cnt         <= CW'(`ADC_SPACING_CYC);
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        `ADC_REG_CTRL: begin
          trigger_edge_select <= edge_sel_e'(bus_req.wdata[`ADC_CTRL_EDGE_BIT]);
          signed_format <= code_fmt_e'(bus_req.wdata[`ADC_CTRL_FMT_MSB:`ADC_CTRL_FMT_LSB]);
        end
        `ADC_REG_SAMPLE:    sample_cnt  <= bus_req.wdata[CW-1:0];
        `ADC_REG_CONVERT:   convert_cnt <= bus_req.wdata[CW-1:0];
        `ADC_REG_READY_DLY: ready_cnt   <= bus_req.wdata[CW-1:0];
        `ADC_REG_SPACING:   spacing_cnt <= bus_req.wdata[CW-1:0];
        default: ;
      endcase
    end
  end

  // sticky ignored-trigger flag; write one to clear, a new drop wins over the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_ignored <= 1'b0;
    end else if (trig_drop) begin
      trig_ignored <= 1'b1;
    end else if (bus_req.wr && bus_req.addr == `ADC_REG_STATUS
                 && bus_req.wdata[`ADC_STAT_IGNORED_BIT]) begin
      trig_ignored <= 1'b0;
    end
  end

  // read data stand in the cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `ADC_REG_CTRL:      bus_rdata <= 32'({signed_format, trigger_edge_select});
        `ADC_REG_SAMPLE:    bus_rdata <= 32'(sample_cnt);
        `ADC_REG_CONVERT:   bus_rdata <= 32'(convert_cnt);
        `ADC_REG_READY_DLY: bus_rdata <= 32'(ready_cnt);
        `ADC_REG_SPACING:   bus_rdata <= 32'(spacing_cnt);
        `ADC_REG_STATUS: begin
          bus_rdata <= 32'h0000_0000;
          bus_rdata[`ADC_STAT_READY_BIT]   <= data_ready;
          bus_rdata[`ADC_STAT_SAMPLE_BIT]  <= sampling;
          bus_rdata[`ADC_STAT_IGNORED_BIT] <= trig_ignored;
          bus_rdata[`ADC_STAT_PEND_LSB +: IW + 1] <= pend_count;
        end
        `ADC_REG_CODE:      bus_rdata <= 32'(code_out);
        default:            bus_rdata <= 32'h0000_0000;
      endcase
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ===== tb/adc_seq_assertions.sv
`timescale 1ns/1ns
module adc_seq_assertions #(
  parameter int          output_width         = 12,
  parameter logic        ready_initial_state  = 1'b1,
  parameter logic [31:0] output_initial_value = 32'h0
) (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire adc_seq_pkg::reg_req_s   bus_req,
  input wire logic [31:0]             bus_rdata,
  input wire logic                    sampling,
  input wire logic [output_width-1:0] code_out,
  input wire logic                    data_ready
);
  import adc_seq_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // five sample cycles, then a gap that no start may enter
  sequence s_phase; sampling[*5] ##1 !sampling; endsequence
  sequence s_quiet; !sampling[*6]; endsequence
  AST_SAMPLE_LEN: assert property ($rose(sampling) |-> s_phase)
    else $error("sample phase length wrong");
  AST_SPACING: assert property ($rose(sampling) |-> ##5 s_quiet)
    else $error("start inside spacing");
  AST_CONV_TIME: assert property ($rose(sampling) |-> ##25 $fell(data_ready))
    else $error("result off conversion time");
  AST_DROP_CAUSE: assert property ($fell(data_ready) |->
    $past(sampling, 25) && !$past(sampling, 26))
    else $error("ready drop without start");
  AST_READY_LOW: assert property ($fell(data_ready) |=> !data_ready ##1 data_ready)
    else $error("ready low time wrong");
  AST_CODE_MOVE: assert property (!$stable(code_out) |-> $fell(data_ready))
    else $error("code moved with ready up");
  AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside answer");
  // reset values are checked while reset is held, from its second edge on
  AST_RESET: assert property (disable iff (1'b0) rst && $past(rst) |-> !sampling &&
    code_out == output_initial_value[output_width-1:0] && data_ready == ready_initial_state)
    else $error("reset values wrong");
endmodule

bind adc_conversion_sequencer adc_seq_assertions #(.output_width(output_width),
  .ready_initial_state(ready_initial_state), .output_initial_value(output_initial_value))
  chk (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .sampling(sampling), .code_out(code_out), .data_ready(data_ready));

// ===== tb/code_reader.sv
`timescale 1ns/1ns
module code_reader #(
  parameter int output_width = 12
) (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire logic [output_width-1:0] code_out,
  input wire logic                    data_ready
);
  logic [output_width-1:0] got[$];
  logic                    ready_q;
  // take a code only once ready returns, as a slow reader would
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= data_ready;
      if (data_ready && !ready_q) begin
        got.push_back(code_out);
      end
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
`include "adc_seq_cfg.svh"
module tb;
  import adc_seq_pkg::*;
  localparam int          W    = 12;
  localparam logic [31:0] INIT = 32'h0000_0A5C;
  logic         clk_sys, rst, trig_pin, sampling, data_ready;
  reg_req_s     bus_req;
  logic [31:0]  bus_rdata, st;
  logic [W-1:0] sample_in, code_out;
  int           fail_count = 0, checks_done = 0, cycles = 0;

  adc_conversion_sequencer #(.output_width(W), .output_initial_value(INIT)) dut (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .trig_pin(trig_pin), .sample_in(sample_in), .sampling(sampling),
    .code_out(code_out), .data_ready(data_ready));
  code_reader #(.output_width(W)) reader (.clk_sys(clk_sys), .rst(rst),
    .code_out(code_out), .data_ready(data_ready));

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(string s, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  // move the pin to its active level, count edges until ready drops
  task automatic fire(logic lvl, output int n);
    @(posedge clk_sys);
    trig_pin <= lvl;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (data_ready !== 1'b0 && n < 60);
  endtask

  // every edge select and format; the pin is set to the opposite level first
  task automatic t_formats();
    int n;
    logic [W-1:0] raw;
    for (int e = 0; e < 2; e++) begin
      for (int f = 0; f < 3; f++) begin
        raw = W'(12'h5E7 * (e * 3 + f + 1));
        wr(`ADC_REG_CTRL, {29'h0, f[1:0], e[0]});
        sample_in <= raw;
        trig_pin <= e[0];
        repeat (6) @(posedge clk_sys);
        fire(~e[0], n);
        // pin to slot start takes three edges: two synchroniser stages and the registered accept
        check("latency", `ADC_CONVERT_CYC + 3, n);
        check("code", (f == 1) ? raw ^ 12'h800 : raw, code_out);
        repeat (4) @(posedge clk_sys);
      end
    end
    $display("test formats done");
  endtask

  // start, early retrigger, then a start just past the spacing
  task automatic t_overlap();
    wr(`ADC_REG_CTRL, 32'h0);
    sample_in <= 12'h2C9;
    trig_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    trig_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    trig_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    trig_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sample_in <= 12'hE14;
    trig_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    trig_pin <= 1'b1;
    repeat (50) @(posedge clk_sys);
    check("count", 8, reader.got.size());
    check("first", 12'h2C9, reader.got[6]);
    check("second", 12'hE14, reader.got[7]);
    rd(`ADC_REG_STATUS, st);
    check("ignored", 1, st[2]);
    wr(`ADC_REG_STATUS, 32'h4);
    rd(`ADC_REG_STATUS, st);
    check("cleared", 0, st[2]);
    rd(`ADC_REG_CODE, st);
    check("code reg", 12'hE14, st);
    rd(8'h40, st);
    check("unmapped", 0, st);
    $display("test overlap done");
  endtask

  // timing defaults read back, then the spare format code on a falling edge
  task automatic t_regs();
    int n;
    rd(`ADC_REG_SAMPLE, st);
    check("sample cnt", `ADC_SAMPLE_CYC, st);
    rd(`ADC_REG_READY_DLY, st);
    check("ready cnt", `ADC_READY_DLY_CYC, st);
    rd(`ADC_REG_CONVERT, st);
    check("convert cnt", `ADC_CONVERT_CYC, st);
    rd(`ADC_REG_SPACING, st);
    check("spacing cnt", `ADC_SPACING_CYC, st);
    check("spacing below convert", 1, st < `ADC_CONVERT_CYC);
    wr(`ADC_REG_CTRL, 32'h7);
    rd(`ADC_REG_CTRL, st);
    check("ctrl", 32'h7, st);
    fire(1'b0, n);
    check("latency fall", `ADC_CONVERT_CYC + 3, n);
    check("spare format", 12'hE14, code_out);
    $display("test regs done");
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // a hung wait ends the run here
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end

  // timing registers stay at defaults, spacing below conversion time
  initial begin
    rst = 1'b1;
    trig_pin = 1'b0;
    sample_in = '0;
    bus_req = '0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check("init code", INIT[W-1:0], code_out);
    check("init ready", 1, data_ready);
    $display("test reset done");
    t_formats();
    t_overlap();
    t_regs();
    conclude();
  end
endmodule
